// ===== src/dsl_lock.sv
// What this block does
// - a programmed 32-bit key in the latch (rewritable until locked) enables permanent security.
// - vote output is one when at least 28 of 32 bits match.
// - when locked, debug and test entry barred and latch changes inhibited.
// - when locked, all test, programming and debug ports disabled.
// - lock needs key load, nonvolatile commit, then reset, in order.
// - latch sampled only at reset; later changes ignored until next reset.
// - key write accepted only while no flash protection is set.
// - access stays open after key write until next reset.
// - latch contents readable over serial wire debug.
// - protection lowered or cleared only by full device erase.
// - block erase, program, verify only if block security allows.
`timescale 1ns/100ps
`default_nettype none
module dsl_lock (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        clk_en_in,
  input  wire logic        key_load_in,
  input  wire logic [31:0] key_data_in,
  input  wire logic        key_commit_in,
  input  wire logic        latch_read_in,
  input  wire logic        prot_wr_in,
  input  wire logic [1:0]  prot_level_in,
  input  wire logic        full_erase_in,
  input  wire logic        blk_op_in,
  input  wire logic [1:0]  blk_kind_in,
  input  wire logic [1:0]  blk_sel_in,
  input  wire logic        sec_wr_in,
  input  wire logic [2:0]  sec_data_in,
  output logic             locked_out,
  output logic             debug_en_out,
  output logic             test_en_out,
  output logic             prog_en_out,
  output logic             key_ack_out,
  output logic             key_nak_out,
  output logic [31:0]      latch_rd_out,
  output logic [1:0]       prot_out,
  output logic             blk_ok_out,
  output logic             blk_rej_out,
  output logic             erase_done_out
);
  dsl_pkg::dsl_state_e state, next_state;
  logic [31:0] vol_key, next_vol_key;
  // power-up value only; a zero latch agrees with the key in 16 bits, so it starts open
  logic [31:0] nv_cells = dsl_pkg::LATCH_RST;
  logic [31:0] next_nv_cells;
  logic        vol_valid, next_vol_valid;
  logic        locked, next_locked;
  logic [1:0]  prot = dsl_pkg::PROT_NONE;
  logic [1:0]  next_prot;
  logic [2:0]  blk_sec [4];
  logic [2:0]  next_blk_sec [4];
  logic        key_ack, next_key_ack;
  logic        key_nak, next_key_nak;
  logic [31:0] latch_rd, next_latch_rd;
  logic        blk_ok, next_blk_ok;
  logic        blk_rej, next_blk_rej;
  logic        erase_done, next_erase_done;
  logic        vote_match;
  logic [5:0]  vote_count;
  logic        sec_allow;
  logic        next_port_en;

  dsl_vote u_vote (
    .latch_bits_in (nv_cells),
    .match_out     (vote_match),
    .count_out     (vote_count)
  );

  always_comb begin
    case (blk_kind_in)
      dsl_pkg::OP_ERASE:  sec_allow = blk_sec[blk_sel_in][dsl_pkg::SEC_ERASE];
      dsl_pkg::OP_PROG:   sec_allow = blk_sec[blk_sel_in][dsl_pkg::SEC_PROG];
      dsl_pkg::OP_VERIFY: sec_allow = blk_sec[blk_sel_in][dsl_pkg::SEC_VERIFY];
      default:            sec_allow = 1'b0;
    endcase
  end

  always_comb begin
    next_state      = state;
    next_vol_key    = vol_key;
    next_nv_cells   = nv_cells;
    next_vol_valid  = vol_valid;
    next_locked     = locked;
    next_prot       = prot;
    next_key_ack    = 1'b0;
    next_key_nak    = 1'b0;
    next_latch_rd   = latch_rd;
    next_blk_ok     = 1'b0;
    next_blk_rej    = 1'b0;
    next_erase_done = 1'b0;
    for (int b = 0; b < 4; b++) begin
      next_blk_sec[b] = blk_sec[b];
    end
    case (state)
      dsl_pkg::DSL_ST_RESET: begin
        next_state = dsl_pkg::DSL_ST_SAMPLE;
      end
      dsl_pkg::DSL_ST_SAMPLE: begin
        // decided once per reset from the committed cells only
        next_locked = vote_match;
        next_state  = dsl_pkg::DSL_ST_RUN;
      end
      dsl_pkg::DSL_ST_RUN: begin
        // all port traffic except latch reads refused once locked
        if (!locked) begin
          if (key_load_in) begin
            if (prot == dsl_pkg::PROT_NONE) begin
              next_vol_key   = key_data_in;
              next_vol_valid = 1'b1;
              next_key_ack   = 1'b1;
            end else begin
              next_key_nak = 1'b1;
            end
          end else if (key_commit_in) begin
            // locked stays low here: access open until reset
            if (vol_valid && prot == dsl_pkg::PROT_NONE) begin
              next_nv_cells = vol_key;
              next_key_ack  = 1'b1;
            end else begin
              next_key_nak = 1'b1;
            end
          end
          if (latch_read_in) begin
            next_latch_rd = nv_cells;
          end
          if (full_erase_in) begin
            next_prot       = dsl_pkg::PROT_NONE;
            next_erase_done = 1'b1;
            for (int b = 0; b < 4; b++) begin
              next_blk_sec[b] = 3'h7;
            end
          end else begin
            // only raising is allowed outside full erase
            if (prot_wr_in && prot_level_in > prot) begin
              next_prot = prot_level_in;
            end
            if (sec_wr_in) begin
              next_blk_sec[blk_sel_in] = blk_sec[blk_sel_in] & sec_data_in;
            end
            if (blk_op_in) begin
              next_blk_ok  = sec_allow;
              next_blk_rej = ~sec_allow;
            end
          end
        end else begin
          // latch contents still identify a secured part
          if (latch_read_in) begin
            next_latch_rd = nv_cells;
          end
          if (key_load_in || key_commit_in) begin
            next_key_nak = 1'b1;
          end
          if (blk_op_in) begin
            next_blk_rej = 1'b1;
          end
        end
      end
      default: begin
        next_state = dsl_pkg::DSL_ST_RESET;
      end
    endcase
    // ports follow the lock decision at the very edge that takes it
    next_port_en = (next_state == dsl_pkg::DSL_ST_RUN) && !next_locked;
  end

  // nonvolatile cells and protection are not cleared by reset
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state      <= dsl_pkg::DSL_ST_RESET;
      vol_key    <= dsl_pkg::LATCH_RST;
      vol_valid  <= 1'b0;
      locked     <= 1'b1;
      key_ack    <= 1'b0;
      key_nak    <= 1'b0;
      latch_rd   <= dsl_pkg::LATCH_RST;
      blk_ok     <= 1'b0;
      blk_rej    <= 1'b0;
      erase_done <= 1'b0;
    end else if (clk_en_in) begin
      state      <= next_state;
      vol_key    <= next_vol_key;
      vol_valid  <= next_vol_valid;
      locked     <= next_locked;
      key_ack    <= next_key_ack;
      key_nak    <= next_key_nak;
      latch_rd   <= next_latch_rd;
      blk_ok     <= next_blk_ok;
      blk_rej    <= next_blk_rej;
      erase_done <= next_erase_done;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (clk_en_in) begin
      nv_cells <= next_nv_cells;
      prot     <= next_prot;
    end
  end

  // one security entry per flash block
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_blk_sec
      always_ff @(posedge sys_clk_in) begin
        if (clk_en_in) begin
          blk_sec[gb] <= next_blk_sec[gb];
        end
      end
    end
  endgenerate

  // ports open only in run state and when not locked
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      debug_en_out <= 1'b0;
      test_en_out  <= 1'b0;
      prog_en_out  <= 1'b0;
    end else if (clk_en_in) begin
      debug_en_out <= next_port_en;
      test_en_out  <= next_port_en;
      prog_en_out  <= next_port_en;
    end
  end

  assign locked_out     = locked;
  assign key_ack_out    = key_ack;
  assign key_nak_out    = key_nak;
  assign latch_rd_out   = latch_rd;
  assign prot_out       = prot;
  assign blk_ok_out     = blk_ok;
  assign blk_rej_out    = blk_rej;
  assign erase_done_out = erase_done;

  chk_lock_holds: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == dsl_pkg::DSL_ST_RUN && clk_en_in) |=> $stable(locked))
    else $error("lock flag changed between resets");

  chk_sample_vote: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == dsl_pkg::DSL_ST_SAMPLE && clk_en_in) |=> (locked == (vote_count >= 6'h1c)))
    else $error("lock flag does not follow vote");

  chk_run_holds: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == dsl_pkg::DSL_ST_RUN) |=> (state == dsl_pkg::DSL_ST_RUN))
    else $error("lock decision taken again without reset");

  chk_ports_closed: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (locked && state == dsl_pkg::DSL_ST_RUN) |=> (!debug_en_out && !prog_en_out))
    else $error("port open while locked");

  chk_test_closed: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (locked && state == dsl_pkg::DSL_ST_RUN) |=> !test_en_out)
    else $error("test port open while locked");

  chk_latch_frozen: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (locked && state == dsl_pkg::DSL_ST_RUN) |=> $stable(nv_cells))
    else $error("latch altered while locked");

  chk_locked_refuse: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && state == dsl_pkg::DSL_ST_RUN && locked && (key_load_in || key_commit_in))
    |=> (key_nak && !key_ack))
    else $error("key operation taken while locked");

  chk_blk_locked: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && state == dsl_pkg::DSL_ST_RUN && locked && blk_op_in)
    |=> (blk_rej && !blk_ok))
    else $error("block op served while locked");

  chk_key_prot: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && state == dsl_pkg::DSL_ST_RUN && !locked && key_load_in
     && prot != 2'h0) |=> (key_nak && $stable(vol_key)))
    else $error("key taken while protected");

  chk_ack_exclusive: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !(key_ack && key_nak))
    else $error("key answered both ways");

  chk_commit_order: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && state == dsl_pkg::DSL_ST_RUN && !key_load_in && key_commit_in
     && !vol_valid) |=> (key_nak && $stable(nv_cells)))
    else $error("commit taken without a loaded key");

  chk_key_lands: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && state == dsl_pkg::DSL_ST_RUN && !locked && !key_load_in && key_commit_in
     && vol_valid && prot == 2'h0) |=> (key_ack && nv_cells == $past(vol_key)))
    else $error("committed key not in cells");

  chk_open_after: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && state == dsl_pkg::DSL_ST_RUN && !locked && key_commit_in)
    |=> ##1 debug_en_out)
    else $error("access closed before reset");

  chk_prot_lower: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && !full_erase_in) |=> (prot >= $past(prot)))
    else $error("protection lowered without erase");

  chk_erase_clears: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && state == dsl_pkg::DSL_ST_RUN && !locked && full_erase_in)
    |=> (prot == 2'h0 && erase_done))
    else $error("full erase left protection set");

  chk_blk_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && blk_op_in && !sec_allow) |=> !blk_ok)
    else $error("block op allowed against security");

  chk_read_latch: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && latch_read_in && state == dsl_pkg::DSL_ST_RUN) |=> (latch_rd == $past(nv_cells)))
    else $error("latch read value wrong");
endmodule
`default_nettype wire

// ===== inc/dsl_pkg.sv
`default_nettype none
package dsl_pkg;
  localparam int unsigned KEY_W      = 32;
  localparam int unsigned CNT_W      = 6;
  // key pattern value is arbitrary, not any vendor code
  localparam logic [31:0] KEY_PATTERN = 32'h5a3c_96e1;
  localparam logic [5:0]  MATCH_MIN   = 6'h1c;
  localparam int unsigned PROT_W     = 2;
  localparam logic [1:0]  PROT_NONE   = 2'h0;
  localparam logic [31:0] LATCH_RST   = 32'h0000_0000;
  localparam int unsigned NBLK       = 4;
  localparam int unsigned BLK_W      = 2;
  // block security bit positions
  localparam int unsigned SEC_ERASE  = 0;
  localparam int unsigned SEC_PROG   = 1;
  localparam int unsigned SEC_VERIFY = 2;
  localparam int unsigned SEC_W      = 3;
  localparam logic [1:0]  OP_NONE    = 2'h0;
  localparam logic [1:0]  OP_ERASE   = 2'h1;
  localparam logic [1:0]  OP_PROG    = 2'h2;
  localparam logic [1:0]  OP_VERIFY  = 2'h3;
  typedef enum logic [1:0] {
    DSL_ST_RESET  = 2'b00,
    DSL_ST_SAMPLE = 2'b01,
    DSL_ST_RUN    = 2'b10
  } dsl_state_e;
endpackage
`default_nettype wire

// ===== src/dsl_vote.sv
`timescale 1ns/100ps
`default_nettype none
module dsl_vote (
  input  wire logic [31:0] latch_bits_in,
  output logic             match_out,
  output logic [5:0]       count_out
);
  logic [31:0] agree;
  logic [5:0]  sum;
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_agree
      assign agree[g] = ~(latch_bits_in[g] ^ dsl_pkg::KEY_PATTERN[g]);
    end
  endgenerate
  always_comb begin
    sum = 6'h00;
    for (int i = 0; i < 32; i++) begin
      sum = sum + {5'h00, agree[i]};
    end
  end
  assign count_out = sum;
  // a few failed cells must not drop the lock
  assign match_out = (sum >= dsl_pkg::MATCH_MIN);
endmodule
`default_nettype wire

// ===== verification/dsl_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module dsl_host_model (
  input  wire logic        clk_in,
  output logic             key_load_out,
  output logic [31:0]      key_data_out,
  output logic             key_commit_out,
  output logic             latch_read_out,
  output logic             prot_wr_out,
  output logic [1:0]       sel_out,
  output logic             full_erase_out,
  output logic             blk_op_out,
  output logic             sec_wr_out,
  output logic [2:0]       arg_out
);
  initial begin
    {key_load_out, key_commit_out, latch_read_out, prot_wr_out} = 4'h0;
    {full_erase_out, blk_op_out, sec_wr_out} = 3'h0;
    key_data_out = 32'h0;
    sel_out = 2'h0;
    arg_out = 3'h0;
  end
  // op: 0 load, 1 commit, 2 read, 3 protect, 4 erase, 5 block op, 6 security
  // callers may commit without a load and may load a key after protecting
  task automatic send(input int op, input logic [31:0] d, input logic [1:0] s,
                      input logic [2:0] a);
    @(negedge clk_in);
    key_data_out = d;
    sel_out = s;
    arg_out = a;
    {key_load_out, key_commit_out, latch_read_out} = {op == 0, op == 1, op == 2};
    {prot_wr_out, full_erase_out} = {op == 3, op == 4};
    {blk_op_out, sec_wr_out} = {op == 5, op == 6};
    @(negedge clk_in);
    {key_load_out, key_commit_out, latch_read_out, prot_wr_out} = 4'h0;
    {full_erase_out, blk_op_out, sec_wr_out} = 3'h0;
    // released lines flip so a stale value cannot pass
    key_data_out = ~d;
    sel_out = ~s;
    arg_out = ~a;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_debug_security_lock.sv
`timescale 1ns/100ps
`default_nettype none
module tb_debug_security_lock;
  localparam logic [31:0] K = dsl_pkg::KEY_PATTERN;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        kl, kc, lr, pw, fe, bo, sw;
  logic        lk, dbg, tst, prg, ack, nak, bok, brej, edn;
  logic [31:0] kd, rd;
  logic [1:0]  sel, prot;
  logic [2:0]  arg;
  int          fails = 0;
  int          n_compared = 0;
  always #20 sys_clk = ~sys_clk;
  dsl_host_model host_u (.clk_in(sys_clk), .key_load_out(kl), .key_data_out(kd),
    .key_commit_out(kc), .latch_read_out(lr), .prot_wr_out(pw), .sel_out(sel),
    .full_erase_out(fe), .blk_op_out(bo), .sec_wr_out(sw), .arg_out(arg));
  dsl_lock dut_u (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .clk_en_in(clk_en),
    .key_load_in(kl), .key_data_in(kd), .key_commit_in(kc), .latch_read_in(lr),
    .prot_wr_in(pw), .prot_level_in(sel), .full_erase_in(fe), .blk_op_in(bo),
    .blk_kind_in(arg[1:0]), .blk_sel_in(sel), .sec_wr_in(sw), .sec_data_in(arg),
    .locked_out(lk), .debug_en_out(dbg), .test_en_out(tst), .prog_en_out(prg),
    .key_ack_out(ack), .key_nak_out(nak), .latch_rd_out(rd), .prot_out(prot),
    .blk_ok_out(bok), .blk_rej_out(brej), .erase_done_out(edn));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({28'h0, lk, dbg, tst, prg}, 32'h8);
    rst_n = 1'b1;
    // first request may be taken at the third edge after release
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic ports(input logic open);
    chk({28'h0, lk, dbg, tst, prg}, open ? 32'h7 : 32'h8);
  endtask
  task automatic keyw(input logic [31:0] d);
    host_u.send(0, d, 2'h0, 3'h0);
    chk({30'h0, ack, nak}, 32'h2);
    host_u.send(1, 32'h0, 2'h0, 3'h0);
    chk({30'h0, ack, nak}, 32'h2);
  endtask
  task automatic t_erase();
    do_reset();
    host_u.send(4, 32'h0, 2'h0, 3'h0);
    chk({29'h0, edn, prot}, 32'h4);
    keyw(~K);
    ports(1'b1);
    host_u.send(2, 32'h0, 2'h0, 3'h0);
    chk(rd, ~K);
    do_reset();
    ports(1'b1);
    $display("t_erase done");
  endtask
  task automatic t_vote();
    // five disagreeing bits leave 27 matches, one short of locking
    keyw(K ^ 32'h0000_001f);
    do_reset();
    ports(1'b1);
    host_u.send(0, K, 2'h0, 3'h0);
    chk({31'h0, ack}, 32'h1);
    do_reset();
    ports(1'b1);
    // volatile store is empty after reset, so a bare commit is refused
    host_u.send(1, 32'h0, 2'h0, 3'h0);
    chk({30'h0, ack, nak}, 32'h1);
    $display("t_vote done");
  endtask
  task automatic t_prot();
    host_u.send(3, 32'h0, 2'h2, 3'h0);
    chk({30'h0, prot}, 32'h2);
    host_u.send(3, 32'h0, 2'h1, 3'h0);
    chk({30'h0, prot}, 32'h2);
    host_u.send(0, K, 2'h0, 3'h0);
    chk({30'h0, ack, nak}, 32'h1);
    host_u.send(4, 32'h0, 2'h0, 3'h0);
    chk({30'h0, prot}, 32'h0);
    clk_en = 1'b0;
    host_u.send(3, 32'h0, 2'h3, 3'h0);
    clk_en = 1'b1;
    chk({30'h0, prot}, 32'h0);
    $display("t_prot done");
  endtask
  task automatic t_blk();
    host_u.send(6, 32'h0, 2'h1, 3'h6);
    host_u.send(5, 32'h0, 2'h1, 3'h1);
    chk({30'h0, bok, brej}, 32'h1);
    host_u.send(5, 32'h0, 2'h1, 3'h2);
    chk({30'h0, bok, brej}, 32'h2);
    host_u.send(5, 32'h0, 2'h1, 3'h3);
    chk({30'h0, bok, brej}, 32'h2);
    host_u.send(5, 32'h0, 2'h0, 3'h1);
    chk({30'h0, bok, brej}, 32'h2);
    // operation code zero names no operation and is always refused
    host_u.send(5, 32'h0, 2'h1, 3'h0);
    chk({30'h0, bok, brej}, 32'h1);
    host_u.send(4, 32'h0, 2'h0, 3'h0);
    host_u.send(5, 32'h0, 2'h1, 3'h1);
    chk({30'h0, bok, brej}, 32'h2);
    $display("t_blk done");
  endtask
  task automatic t_lock();
    // exactly 28 matching bits must still lock
    keyw(K ^ 32'hf000_0000);
    ports(1'b1);
    do_reset();
    ports(1'b0);
    host_u.send(0, K, 2'h0, 3'h0);
    chk({30'h0, ack, nak}, 32'h1);
    host_u.send(5, 32'h0, 2'h0, 3'h2);
    chk({30'h0, bok, brej}, 32'h1);
    host_u.send(3, 32'h0, 2'h3, 3'h0);
    chk({30'h0, prot}, 32'h0);
    host_u.send(4, 32'h0, 2'h0, 3'h0);
    chk({31'h0, edn}, 32'h0);
    host_u.send(2, 32'h0, 2'h0, 3'h0);
    chk(rd, K ^ 32'hf000_0000);
    $display("t_lock done");
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    print_verdict();
  end
  initial begin
    t_erase();
    t_vote();
    t_prot();
    t_blk();
    t_lock();
    print_verdict();
  end
endmodule
`default_nettype wire
